// File: design/nvs_ctrl.sv
// Host-side controller for a nonvolatile SRAM: plain reads and writes,
// software command sequences, and pin-requested stores over the busy pin.
// Assumes the busy pin wire is resolved outside from its enable with a pull-up.
// ----------------------------------------------------------------
// Functional notes
// - Five fixed prefix reads first
// - Sixth read 0x8fc0 stores
// - Sixth read 0x4c63 recalls
// - Sixth read 0x8b45 disables save
// - No access inside a sequence
// - Six reads with write strobe high
// - Sixth read 0x4b46 enables save
// - Save setting persists after manual store; the controller issues a store right after each save change
module nvs_ctrl #(
  parameter int ADDR_W          = nvs_ctrl_pkg::ADDR_W,
  parameter int DATA_W          = nvs_ctrl_pkg::DATA_W,
  parameter int STORE_CYC       = 80000,
  parameter int RECALL_CYC      = 2000,
  parameter int GRACE_CYC       = 250,
  parameter int PERSIST_AFTER_SAVE = 1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic [2:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic [1:0]        cmd_lanes_n,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_blocked,
  output logic                   dev_busy,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_cs_n,
  output logic                   mem_we_n,
  output logic                   mem_oe_n,
  output logic                   mem_upper_byte_lane_n,
  output logic                   mem_lower_byte_lane_n,
  input  wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0]      mem_dq_o,
  output logic                   mem_dq_oe_n,
  input  wire logic              store_busy_n_i,
  output logic                   store_busy_n_o,
  output logic                   store_busy_n_oe_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic              bsy_s1_r, bsy_s2_r;

  // Pin inputs are asynchronous; busy counts as low until seen high through both stages
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dq_s1_r  <= '0;
      dq_s2_r  <= '0;
      bsy_s1_r <= 1'b0;
      bsy_s2_r <= 1'b0;
    end
    else
    begin
      dq_s1_r  <= mem_dq_i;
      dq_s2_r  <= dq_s1_r;
      bsy_s1_r <= store_busy_n_i;
      bsy_s2_r <= bsy_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ACCESS, S_SEQ, S_PIN, S_WAIT, S_RESP} ctl_state_t;

  ctl_state_t        state_r, state_nxt;
  logic [2:0]        step_r, step_nxt;
  logic [2:0]        op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [1:0]        lanes_r, lanes_nxt;
  logic [31:0]       wait_r, wait_nxt;
  logic              blk_r, blk_nxt;
  logic              ready_r, ready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              pin_low_r, pin_low_nxt;

  logic              stb_start;
  logic              stb_write;
  logic [ADDR_W-1:0] stb_addr;
  logic              stb_busy;
  logic              stb_done;
  logic [DATA_W-1:0] stb_rdata;
  logic [ADDR_W-1:0] p_addr;
  logic              p_cs_n, p_we_n, p_oe_n, p_dq_oe_n;
  logic [1:0]        p_lane_n;
  logic [DATA_W-1:0] p_dq_o;

  // Address for each step of the sequence; the sixth comes from the command code
  function automatic logic [15:0] seq_word(input logic [2:0] step, input logic [2:0] op);
    logic [15:0] w;
    w = 16'h0000;
    case (step)
      3'h0: w = nvs_ctrl_pkg::SEQ_ADDR_0;
      3'h1: w = nvs_ctrl_pkg::SEQ_ADDR_1;
      3'h2: w = nvs_ctrl_pkg::SEQ_ADDR_2;
      3'h3: w = nvs_ctrl_pkg::SEQ_ADDR_3;
      3'h4: w = nvs_ctrl_pkg::SEQ_ADDR_4;
      default:
      begin
        if (op == nvs_ctrl_pkg::OP_STORE)
          w = nvs_ctrl_pkg::CMD_STORE;
        else if (op == nvs_ctrl_pkg::OP_RECALL)
          w = nvs_ctrl_pkg::CMD_RECALL;
        else if (op == nvs_ctrl_pkg::OP_SAVE_OFF)
          w = nvs_ctrl_pkg::CMD_SAVE_OFF;
        else
          w = nvs_ctrl_pkg::CMD_SAVE_ON;
      end
    endcase
    return w;
  endfunction

  // Upper address bits are don't-care to the device detector and are sent as zero
  assign stb_addr  = (state_r == S_SEQ) ? ADDR_W'(seq_word(step_r, op_r)) : addr_r;
  assign stb_write = (state_r == S_ACCESS) && (op_r == nvs_ctrl_pkg::OP_WRITE);
  assign stb_start = ((state_r == S_ACCESS) || (state_r == S_SEQ)) && !stb_busy && !stb_done;

  // Main sequencing; the device refuses accesses while busy is low so none are issued
  always_comb
  begin
    state_nxt   = state_r;
    step_nxt    = step_r;
    op_nxt      = op_r;
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    lanes_nxt   = lanes_r;
    wait_nxt    = wait_r;
    blk_nxt     = blk_r;
    ready_nxt   = 1'b0;
    rvalid_nxt  = 1'b0;
    rdata_nxt   = rdata_r;
    pin_low_nxt = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        ready_nxt = bsy_s2_r;
        if (cmd_valid && ready_r)
        begin
          ready_nxt = 1'b0;
          op_nxt    = cmd_op;
          addr_nxt  = cmd_addr;
          wdata_nxt = cmd_wdata;
          lanes_nxt = cmd_lanes_n;
          step_nxt  = 3'h0;
          blk_nxt   = 1'b0;
          if (cmd_op == nvs_ctrl_pkg::OP_READ || cmd_op == nvs_ctrl_pkg::OP_WRITE)
            state_nxt = S_ACCESS;
          else if (cmd_op == nvs_ctrl_pkg::OP_PIN_STORE)
          begin
            wait_nxt  = 32'(GRACE_CYC);
            state_nxt = S_PIN;
          end
          else
          begin
            lanes_nxt = 2'h0;
            state_nxt = S_SEQ;
          end
        end
      end
      S_ACCESS:
      begin
        if (stb_done)
        begin
          rdata_nxt = stb_rdata;
          state_nxt = S_RESP;
        end
      end
      S_SEQ:
      begin
        // Back-to-back reads, nothing else on the pins until all six are out
        if (stb_done)
        begin
          if (step_r == 3'(nvs_ctrl_pkg::SEQ_LEN - 1))
          begin
            if (op_r == nvs_ctrl_pkg::OP_STORE)
              wait_nxt = 32'(STORE_CYC);
            else if (op_r == nvs_ctrl_pkg::OP_RECALL)
              wait_nxt = 32'(RECALL_CYC);
            else
              wait_nxt = 32'(nvs_ctrl_pkg::BUSY_TIMEOUT_CYC);
            if (PERSIST_AFTER_SAVE != 0 && op_r >= nvs_ctrl_pkg::OP_SAVE_OFF)
              op_nxt = nvs_ctrl_pkg::OP_STORE;
            else
              state_nxt = S_WAIT;
            step_nxt = 3'h0;
          end
          else
            step_nxt = step_r + 3'h1;
        end
      end
      S_PIN:
      begin
        // Pull busy low through the grace time, then release and wait on the device
        pin_low_nxt = 1'b1;
        if (wait_r == 32'h0)
        begin
          pin_low_nxt = 1'b0;
          wait_nxt    = 32'(STORE_CYC);
          state_nxt   = S_WAIT;
        end
        else
          wait_nxt = wait_r - 32'h1;
      end
      S_WAIT:
      begin
        // Busy low from the device marks a transfer; release counts only after the time runs out
        if (wait_r != 32'h0)
          wait_nxt = wait_r - 32'h1;
        else if (bsy_s2_r)
          state_nxt = S_RESP;
        if (!bsy_s2_r)
          blk_nxt = 1'b1;
      end
      default:
      begin
        rvalid_nxt = 1'b1;
        state_nxt  = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= S_IDLE;
      step_r    <= 3'h0;
      op_r      <= 3'h0;
      addr_r    <= '0;
      wdata_r   <= '0;
      lanes_r   <= 2'h3;
      wait_r    <= 32'h0;
      blk_r     <= 1'b0;
      ready_r   <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      pin_low_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      step_r    <= step_nxt;
      op_r      <= op_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      lanes_r   <= lanes_nxt;
      wait_r    <= wait_nxt;
      blk_r     <= blk_nxt;
      ready_r   <= ready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      pin_low_r <= pin_low_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------
  nvs_strobe #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_strobe (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (stb_start),
    .is_write    (stb_write),
    .lanes_n     (lanes_r),
    .addr        (stb_addr),
    .wdata       (wdata_r),
    .dq_sync     (dq_s2_r),
    .busy        (stb_busy),
    .done        (stb_done),
    .rdata       (stb_rdata),
    .pin_addr    (p_addr),
    .pin_cs_n    (p_cs_n),
    .pin_we_n    (p_we_n),
    .pin_oe_n    (p_oe_n),
    .pin_lane_n  (p_lane_n),
    .pin_dq_o    (p_dq_o),
    .pin_dq_oe_n (p_dq_oe_n)
  );

  // Outputs re-registered so every top port comes from a flip-flop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_addr              <= '0;
      mem_cs_n              <= 1'b1;
      mem_we_n              <= 1'b1;
      mem_oe_n              <= 1'b1;
      mem_upper_byte_lane_n <= 1'b1;
      mem_lower_byte_lane_n <= 1'b1;
      mem_dq_o              <= '0;
      mem_dq_oe_n           <= 1'b1;
      store_busy_n_o        <= 1'b1;
      store_busy_n_oe_n     <= 1'b1;
      dev_busy              <= 1'b0;
    end
    else
    begin
      mem_addr              <= p_addr;
      mem_cs_n              <= p_cs_n;
      mem_we_n              <= p_we_n;
      mem_oe_n              <= p_oe_n;
      mem_upper_byte_lane_n <= p_lane_n[1];
      mem_lower_byte_lane_n <= p_lane_n[0];
      mem_dq_o              <= p_dq_o;
      mem_dq_oe_n           <= p_dq_oe_n;
      store_busy_n_o        <= 1'b0;
      store_busy_n_oe_n     <= !pin_low_nxt;
      dev_busy              <= !bsy_s2_r;
    end
  end

  assign cmd_ready   = ready_r;
  assign rsp_valid   = rvalid_r;
  assign rsp_rdata   = rdata_r;
  assign rsp_blocked = blk_r;

endmodule

// File: design/nvs_ctrl_pkg.sv
// Constants shared by the nonvolatile SRAM controller and its pin sequencer.
// Assumes a 10 MHz system clock and an asynchronous nonvolatile SRAM on the far side.
package nvs_ctrl_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Command sequence addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQ_ADDR_0      = 16'h4e38;
  localparam logic [15:0] SEQ_ADDR_1      = 16'hb1c7;
  localparam logic [15:0] SEQ_ADDR_2      = 16'h83e0;
  localparam logic [15:0] SEQ_ADDR_3      = 16'h7c1f;
  localparam logic [15:0] SEQ_ADDR_4      = 16'h703f;
  localparam logic [15:0] CMD_STORE       = 16'h8fc0;
  localparam logic [15:0] CMD_RECALL      = 16'h4c63;
  localparam logic [15:0] CMD_SAVE_OFF    = 16'h8b45;
  localparam logic [15:0] CMD_SAVE_ON     = 16'h4b46;
  localparam int          SEQ_LEN         = 6;

  // ----------------------------------------------------------------
  // User command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_READ     = 3'h0;
  localparam logic [2:0] OP_WRITE    = 3'h1;
  localparam logic [2:0] OP_STORE    = 3'h2;
  localparam logic [2:0] OP_RECALL   = 3'h3;
  localparam logic [2:0] OP_SAVE_OFF = 3'h4;
  localparam logic [2:0] OP_SAVE_ON  = 3'h5;
  localparam logic [2:0] OP_PIN_STORE = 3'h6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int ACCESS_TIME_NS      = 45;
  localparam int ACCESS_CYC          = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int STROBE_CYC          = 1;
  localparam int BUSY_TIMEOUT_CYC    = 8;
  localparam int CNT_W               = 8;

endpackage

// File: design/nvs_strobe.sv
// One asynchronous SRAM cycle on the pins: address, select, drive or write strobe.
// Assumes the caller holds addr/data stable while busy is high.
module nvs_strobe #(
  parameter int ADDR_W = nvs_ctrl_pkg::ADDR_W,
  parameter int DATA_W = nvs_ctrl_pkg::DATA_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [1:0]        lanes_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_sync,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic [ADDR_W-1:0]      pin_addr,
  output logic                   pin_cs_n,
  output logic                   pin_we_n,
  output logic                   pin_oe_n,
  output logic [1:0]             pin_lane_n,
  output logic [DATA_W-1:0]      pin_dq_o,
  output logic                   pin_dq_oe_n
);

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD} stb_state_t;

  stb_state_t               state_r, state_nxt;
  logic [7:0]               cnt_r, cnt_nxt;
  logic                     wr_r, wr_nxt;
  logic [DATA_W-1:0]        rdata_r, rdata_nxt;
  logic [ADDR_W-1:0]        addr_r, addr_nxt;
  logic [DATA_W-1:0]        wdata_r, wdata_nxt;
  logic [1:0]               lane_r, lane_nxt;
  logic                     done_r, done_nxt;
  // Read wait covers access time plus the two-flop input synchroniser
  localparam logic [7:0] RD_WAIT = 8'(nvs_ctrl_pkg::ACCESS_CYC + 2);

  // Next-state: address settles a cycle before strobes so the write has setup
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = wr_r;
    rdata_nxt = rdata_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    lane_nxt  = lane_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          addr_nxt  = addr;
          wdata_nxt = wdata;
          lane_nxt  = lanes_n;
          wr_nxt    = is_write;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        cnt_nxt   = wr_r ? 8'(nvs_ctrl_pkg::STROBE_CYC) : RD_WAIT;
        state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (cnt_r == 8'h00)
        begin
          if (!wr_r)
            rdata_nxt = dq_sync;
          state_nxt = ST_HOLD;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      default:
      begin
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      rdata_r <= '0;
      addr_r  <= '0;
      wdata_r <= '0;
      lane_r  <= 2'h3;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      rdata_r <= rdata_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      lane_r  <= lane_nxt;
      done_r  <= done_nxt;
    end
  end

  // Pin drive; write data lands when the write strobe rises out of ST_ACTIVE
  always_comb
  begin
    pin_addr    = addr_r;
    pin_cs_n    = !(state_r == ST_ACTIVE);
    pin_we_n    = !(state_r == ST_ACTIVE && wr_r);
    pin_oe_n    = !(state_r == ST_ACTIVE && !wr_r);
    pin_lane_n  = (state_r == ST_IDLE) ? 2'h3 : lane_r;
    pin_dq_o    = wdata_r;
    pin_dq_oe_n = !(wr_r && state_r != ST_IDLE);
    busy        = (state_r != ST_IDLE);
    done        = done_r;
    rdata       = rdata_r;
  end

endmodule

// File: verif/nvs_ctrl_assertions.sv
// Concurrent checks on the nonvolatile SRAM controller ports.
// Assumes it is bound into nvs_ctrl with the default bus widths.
module nvs_ctrl_assertions (
  input wire logic                             clk_sys,
  input wire logic                             rst,
  input wire logic                             cmd_valid,
  input wire logic [2:0]                       cmd_op,
  input wire logic                             cmd_ready,
  input wire logic                             rsp_valid,
  input wire logic                             dev_busy,
  input wire logic [nvs_ctrl_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                             mem_cs_n,
  input wire logic                             mem_we_n,
  input wire logic                             mem_oe_n,
  input wire logic                             mem_dq_oe_n,
  input wire logic                             store_busy_n_i,
  input wire logic                             store_busy_n_o,
  input wire logic                             store_busy_n_oe_n
);
  // ----------------------------------------------------------------
  // Command to pin relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Every command but the pin store opens with a strobe
  sequence s_take_access;
    cmd_valid && cmd_ready && cmd_op != nvs_ctrl_pkg::OP_PIN_STORE;
  endsequence
  sequence s_strobe_begins;
    ##[1:4] $fell(mem_cs_n);
  endsequence

  a_take_strobe: assert property (s_take_access |-> s_strobe_begins)
    else $error("no strobe after command");
  a_rw_answer: assert property (cmd_valid && cmd_ready && cmd_op <= nvs_ctrl_pkg::OP_WRITE |-> ##[4:20] rsp_valid)
    else $error("read or write never answered");
  a_pin_pull: assert property (cmd_valid && cmd_ready && cmd_op == nvs_ctrl_pkg::OP_PIN_STORE |-> ##[1:4] !store_busy_n_oe_n)
    else $error("busy pin not pulled for pin store");
  a_read_we_high: assert property (!mem_cs_n && !mem_oe_n |-> mem_we_n)
    else $error("write strobe low during read");
  a_write_oe_high: assert property (!mem_we_n |-> !mem_cs_n && mem_oe_n && !mem_dq_oe_n)
    else $error("bad pin mix during write");
  a_addr_steady: assert property (!mem_cs_n && !$past(mem_cs_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  // Starting a cycle into a held busy pin would be refused by the part
  a_start_pin_high: assert property ($fell(mem_cs_n) |-> store_busy_n_i)
    else $error("access started with busy pin low");
  a_busy_ready: assert property (dev_busy && $past(dev_busy) |-> !cmd_ready)
    else $error("ready while device busy");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_pull_only_low: assert property (!store_busy_n_oe_n |-> !store_busy_n_o)
    else $error("busy pin driven high");
endmodule

bind nvs_ctrl nvs_ctrl_assertions u_nvs_ctrl_assertions (
  .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .dev_busy(dev_busy), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
  .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_oe_n(mem_dq_oe_n), .store_busy_n_i(store_busy_n_i),
  .store_busy_n_o(store_busy_n_o), .store_busy_n_oe_n(store_busy_n_oe_n)
);

// File: verif/nvs_device_model.sv
// Behavioural nonvolatile SRAM: 256 words, command sequences, busy pin.
// Assumes the bench resolves the busy pin with a pull-up; times in clk_sys cycles.
module nvs_device_model #(
  parameter int STORE_T  = 20,
  parameter int RECALL_T = 20,
  parameter int GRACE_T  = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        pwr_ok,
  input  wire logic [17:0] addr,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        upper_n,
  input  wire logic        lower_n,
  input  wire logic [15:0] dq_in,
  input  wire logic        busy_pin,
  output logic [15:0]      dq_out,
  output logic             pull_n
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [15:0] PRE [5] = '{nvs_ctrl_pkg::SEQ_ADDR_0, nvs_ctrl_pkg::SEQ_ADDR_1,
    nvs_ctrl_pkg::SEQ_ADDR_2, nvs_ctrl_pkg::SEQ_ADDR_3, nvs_ctrl_pkg::SEQ_ADDR_4};
  logic [15:0] sram [256];
  logic [15:0] nv   [256];
  logic        save_en = 1'b1;
  logic        pend    = 1'b0;
  logic        rd_q    = 1'b0;
  logic        wr_q    = 1'b0;
  logic        pin_q   = 1'b1;
  logic        pwr_q   = 1'b0;
  logic [17:0] a_q     = 18'h0;
  logic [15:0] d_q     = 16'h0;
  logic [1:0]  l_q     = 2'h3;
  logic [15:0] last    = 16'h0;
  int          step    = 0;
  int          cnt     = 0;
  int          grace   = 0;

  initial for (int i = 0; i < 256; i++) begin sram[i] = 16'h0; nv[i] = 16'h0; end

  // Accesses are refused during transfers, low supply or a held pin
  wire rd = !cs_n && !oe_n && we_n && busy_pin && cnt == 0 && pwr_ok;
  wire wr = !cs_n && !we_n && busy_pin && cnt == 0 && pwr_ok;
  assign pull_n = !(cnt != 0 || !pwr_ok || !pwr_q);

  // Unselected lanes show a changing pattern, never a stale word
  assign dq_out = rd ? {upper_n ? ~last[15:8] : sram[addr[7:0]][15:8], lower_n ? ~last[7:0] : sram[addr[7:0]][7:0]}
                     : ~last;

  always @(posedge clk_sys)
  begin
    rd_q <= rd; wr_q <= wr; pin_q <= busy_pin; pwr_q <= pwr_ok; last <= dq_out;
    if (cnt != 0) cnt <= cnt - 1;
    if (grace != 0) grace <= grace - 1;
    if (rd) a_q <= addr;
    if (wr)
    begin
      a_q <= addr; d_q <= dq_in; l_q <= {upper_n, lower_n};
    end
    if (wr_q && !wr)
    begin
      if (!l_q[1]) sram[a_q[7:0]][15:8] = d_q[15:8];
      if (!l_q[0]) sram[a_q[7:0]][7:0] = d_q[7:0];
      pend <= 1'b1;
      step <= 0;
    end
    if (rd_q && !rd)
    begin
      if (step == 5)
      begin
        step <= 0;
        case (a_q[14:2])
          nvs_ctrl_pkg::CMD_STORE[14:2]:    begin nv = sram; pend <= 1'b0; cnt <= STORE_T; end
          nvs_ctrl_pkg::CMD_RECALL[14:2]:   begin sram = nv; pend <= 1'b0; cnt <= RECALL_T; end
          nvs_ctrl_pkg::CMD_SAVE_OFF[14:2]: save_en <= 1'b0;
          nvs_ctrl_pkg::CMD_SAVE_ON[14:2]:  save_en <= 1'b1;
          default: ;
        endcase
      end
      else if (a_q[14:2] == PRE[step][14:2]) step <= step + 1;
      else step <= (a_q[14:2] == PRE[0][14:2]) ? 1 : 0;
    end
    // Pin request runs only with a write pending, after the grace time
    if (pin_q && !busy_pin && cnt == 0 && pend && pwr_ok) grace <= GRACE_T;
    if (grace == 1) begin nv = sram; pend <= 1'b0; cnt <= STORE_T; end
    if (pwr_q && !pwr_ok && save_en && pend) begin nv = sram; pend <= 1'b0; end
    if (!pwr_q && pwr_ok) begin sram = nv; pend <= 1'b0; cnt <= RECALL_T; end
  end
endmodule

// File: verif/test_nvs_ctrl.sv
// Self-checking bench for nvs_ctrl against the behavioural device model.
// Assumes short sim durations; the busy pin has a pull-up in the bench.
module test_nvs_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, pwr_ok = 1'b0, ext_pull = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [17:0] cmd_addr = 18'h0, mem_addr, a;
  logic [15:0] cmd_wdata = 16'h0, rsp_rdata, mem_dq_o, dev_dq, d;
  logic [1:0]  cmd_lanes_n = 2'h0;
  logic        cmd_ready, rsp_valid, rsp_blocked, dev_busy, mem_cs_n, mem_we_n, mem_oe_n, up_n, lo_n;
  logic        mem_dq_oe_n, busy_o, busy_oe_n, dev_pull_n;
  logic [15:0] sram_e [256];
  logic [15:0] nv_e   [256];
  int          bad_count = 0, total_checks = 0, cycles = 0;
  // Open drain pin: any party pulling wins, else the pull-up
  wire         busy_pin = (busy_oe_n | busy_o) & dev_pull_n & !ext_pull;

  always #50 clk_sys = ~clk_sys;

  nvs_ctrl #(.STORE_CYC(20), .RECALL_CYC(20), .GRACE_CYC(5)) dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_lanes_n(cmd_lanes_n), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_blocked(rsp_blocked), .dev_busy(dev_busy), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_upper_byte_lane_n(up_n),
    .mem_lower_byte_lane_n(lo_n), .mem_dq_i(dev_dq), .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n),
    .store_busy_n_i(busy_pin), .store_busy_n_o(busy_o), .store_busy_n_oe_n(busy_oe_n));

  nvs_device_model u_dev (
    .clk_sys(clk_sys), .pwr_ok(pwr_ok), .addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n),
    .oe_n(mem_oe_n), .upper_n(up_n), .lower_n(lo_n), .dq_in(mem_dq_oe_n ? ~mem_dq_o : mem_dq_o),
    .busy_pin(busy_pin), .dq_out(dev_dq), .pull_n(dev_pull_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input bit ok, input string what);
    total_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  function logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] ln);
    merge = {ln[1] ? o[15:8] : n[15:8], ln[0] ? o[7:0] : n[7:0]};
  endfunction

  // Offer one command, hold it to the take edge, wait for its answer
  task do_cmd(input logic [2:0] op, input logic [17:0] ad, input logic [15:0] wd, input logic [1:0] ln);
    @(posedge clk_sys);
    cmd_valid <= 1'b1; cmd_op <= op; cmd_addr <= ad; cmd_wdata <= wd; cmd_lanes_n <= ln;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do @(negedge clk_sys); while (rsp_valid !== 1'b1);
  endtask

  task wr(input logic [17:0] ad, input logic [15:0] wd, input logic [1:0] ln);
    do_cmd(nvs_ctrl_pkg::OP_WRITE, ad, wd, ln);
    sram_e[ad[7:0]] = merge(sram_e[ad[7:0]], wd, ln);
  endtask

  task rd_chk(input logic [17:0] ad);
    do_cmd(nvs_ctrl_pkg::OP_READ, ad, 16'h0, 2'h0);
    check(rsp_rdata === sram_e[ad[7:0]], "read data");
  endtask

  task power_cycle;
    @(posedge clk_sys);
    pwr_ok <= 1'b0;
    repeat (10) @(negedge clk_sys);
    check(cmd_ready === 1'b0, "ready while unpowered");
    @(posedge clk_sys);
    pwr_ok <= 1'b1;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin bad_count++; wrap_up; end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++) begin sram_e[i] = 16'h0; nv_e[i] = 16'h0; end
    void'($urandom(83));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    pwr_ok <= 1'b1;
    repeat (8)
    begin
      a = {10'h0, 8'($urandom)};
      d = 16'($urandom);
      wr(a, d, 2'h0);
      wr(a, 16'($urandom), 2'($urandom));
      rd_chk(a);
    end
    // Back-to-back half writes and a write with both lanes off
    wr(18'h0, 16'h1234, 2'h1);
    wr(18'h0, 16'habcd, 2'h2);
    wr(18'hff, 16'h0, 2'h3);
    rd_chk(18'h0);
    rd_chk(18'hff);
    do_cmd(nvs_ctrl_pkg::OP_STORE, 18'h0, 16'h0, 2'h0);
    nv_e = sram_e;
    // Pin held low from outside with nothing pending blocks commands
    @(posedge clk_sys);
    ext_pull <= 1'b1;
    repeat (5) @(negedge clk_sys);
    check(cmd_ready === 1'b0 && dev_busy === 1'b1, "held busy pin");
    @(posedge clk_sys);
    ext_pull <= 1'b0;
    wr(18'h0, 16'h5a5a, 2'h0);
    do_cmd(nvs_ctrl_pkg::OP_RECALL, 18'h0, 16'h0, 2'h0);
    sram_e = nv_e;
    rd_chk(18'h0);
    wr(18'h7, 16'h0f0f, 2'h0);
    do_cmd(nvs_ctrl_pkg::OP_PIN_STORE, 18'h0, 16'h0, 2'h0);
    nv_e = sram_e;
    wr(18'h7, 16'hf0f0, 2'h0);
    do_cmd(nvs_ctrl_pkg::OP_RECALL, 18'h0, 16'h0, 2'h0);
    sram_e = nv_e;
    rd_chk(18'h7);
    // Supply loss with save off keeps the old image, with save on takes the new
    do_cmd(nvs_ctrl_pkg::OP_SAVE_OFF, 18'h0, 16'h0, 2'h0);
    check(rsp_blocked === 1'b1, "save change not stored");
    wr(18'h7, 16'h3c3c, 2'h0);
    power_cycle;
    sram_e = nv_e;
    rd_chk(18'h7);
    do_cmd(nvs_ctrl_pkg::OP_SAVE_ON, 18'h0, 16'h0, 2'h0);
    wr(18'h7, 16'hc3c3, 2'h0);
    power_cycle;
    nv_e = sram_e;
    rd_chk(18'h7);
    wrap_up;
  end
endmodule
